// ==== hdl/clkgen_pkg.sv ====
package clkgen_pkg;

   localparam int ADDR_W = 28;
   localparam int DATA_W = 32;
   localparam int CNT_W  = 11;

   // register byte addresses
   localparam logic [ADDR_W-1:0] OFF_PERIPH_ENABLE  = 28'hFFFFC10;
   localparam logic [ADDR_W-1:0] OFF_PERIPH_DISABLE = 28'hFFFFC14;
   localparam logic [ADDR_W-1:0] OFF_PERIPH_STATE   = 28'hFFFFC18;
   localparam logic [ADDR_W-1:0] OFF_OSC_CTRL       = 28'hFFFFC20;
   localparam logic [ADDR_W-1:0] OFF_FREQ           = 28'hFFFFC24;
   localparam logic [ADDR_W-1:0] OFF_FIRST_PLL      = 28'hFFFFC28;
   localparam logic [ADDR_W-1:0] OFF_SECOND_PLL     = 28'hFFFFC2C;
   localparam logic [ADDR_W-1:0] OFF_STATUS         = 28'hFFFFC68;

   // main_oscillator_ctrl fields
   localparam int OSC_EN_BIT  = 0;
   localparam int OSC_BYP_BIT = 1;
   localparam int OSC_CNT_LSB = 8;
   localparam int OSC_CNT_W   = 8;

   // main_clock_frequency fields
   localparam int FREQ_LSB       = 0;
   localparam int FREQ_W         = 16;
   localparam int FREQ_VALID_BIT = 16;

   // pll config fields
   localparam int PLL_DIV_LSB   = 0;
   localparam int PLL_DIV_W     = 8;
   localparam int PLL_CNT_LSB   = 8;
   localparam int PLL_CNT_W     = 6;
   localparam int PLL_RANGE_LSB = 14;
   localparam int PLL_RANGE_W   = 2;
   localparam int PLL_MUL_LSB   = 16;
   localparam int PLL_MUL_W     = 11;
   localparam int USB_DIV_LSB   = 28;
   localparam int USB_DIV_W     = 2;

   // clock_status_register bits
   localparam int STAT_OSC_BIT   = 0;
   localparam int STAT_FIRST_PLL_LOCK_FLAG_BIT = 1;
   localparam int STAT_SECOND_PLL_LOCK_FLAG_BIT = 2;

   // reset values
   localparam logic [DATA_W-1:0] PERIPH_RST    = 32'h0000_0000;
   localparam logic [DATA_W-1:0] PERIPH_MASK   = 32'hFFFF_FFFC;
   localparam logic [DATA_W-1:0] PLL_RST       = 32'h0000_0000;
   localparam logic [DATA_W-1:0] STATUS_FIXED  = 32'h0000_0008;
   localparam logic [OSC_CNT_W-1:0] OSC_CNT_RST = 8'h00;

   // timing counts in slow clock periods
   localparam int STARTUP_TICKS_PER_COUNT = 8;
   localparam int MEAS_WINDOW_TICKS       = 16;
   localparam logic [4:0] MEAS_WINDOW     = 5'(MEAS_WINDOW_TICKS);

   typedef enum logic [1:0] {
      MEAS_IDLE = 2'b00,
      MEAS_ARM  = 2'b01,
      MEAS_RUN  = 2'b10,
      MEAS_DONE = 2'b11
   } meas_state_t;

   typedef enum logic [1:0] {
      USB_DIV_1    = 2'b00,
      USB_DIV_2    = 2'b01,
      USB_DIV_4    = 2'b10,
      USB_DIV_RSVD = 2'b11
   } usb_div_t;

   // decoded pll settings for the analog macro
   typedef struct packed {
      logic                   on;
      logic                   ref_zero;
      logic                   ref_bypass;
      logic [PLL_DIV_W-1:0]   ref_divisor;
      logic [PLL_MUL_W:0]     mult_factor;
      logic [PLL_RANGE_W-1:0] range;
   } pll_ctrl_t;

   function automatic pll_ctrl_t decode_pll(input logic [DATA_W-1:0] cfg);
      pll_ctrl_t p;
      logic [PLL_DIV_W-1:0] d;
      logic [PLL_MUL_W-1:0] m;
      d = cfg[PLL_DIV_LSB +: PLL_DIV_W];
      m = cfg[PLL_MUL_LSB +: PLL_MUL_W];
      p.on          = (m != '0);
      p.ref_zero    = (d == 8'h00);
      p.ref_bypass  = (d == 8'h01);
      p.ref_divisor = d;
      p.mult_factor = {1'b0, m} + 12'h001;
      p.range       = cfg[PLL_RANGE_LSB +: PLL_RANGE_W];
      return p;
   endfunction

endpackage

// ==== hdl/slow_tick_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
// waits a loaded number of slow clock ticks, then holds done
module slow_tick_counter (
   input  wire logic                       i_clk,
   input  wire logic                       i_rst_n,
   input  wire logic                       i_load,
   input  wire logic                       i_stop,
   input  wire logic [clkgen_pkg::CNT_W-1:0] i_load_value,
   input  wire logic                       i_tick,
   output logic                            o_done
);

   typedef struct packed {
      logic [clkgen_pkg::CNT_W-1:0] remain;
      logic                         running;
      logic                         done;
   } tick_state_t;

   tick_state_t st;
   tick_state_t next_st;

   always_comb begin
      next_st = st;
      if (i_stop) begin
         next_st = '0;
      end else if (i_load) begin
         next_st.remain  = i_load_value;
         next_st.running = 1'b1;
         next_st.done    = 1'b0;
      end else if (st.running) begin
         if (st.remain == '0) begin
            next_st.running = 1'b0;
            next_st.done    = 1'b1;
         end else if (i_tick) begin
            next_st.remain = st.remain - 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_done = st.done;

endmodule
`default_nettype wire

// ==== hdl/clock_generator.sv ====
// What this block does
// R1: peripheral status bits show running clocks; bits 0 and 1 always read 0
// R2: oscillator enable bit written 1 starts the oscillator, 0 stops it
// R3: stable flag rises only after the full start-up period elapses
// R4: start-up period is start-up count times eight slow clock cycles
// R5: bypass sets stable flag at once and takes main clock from pin
// R6: enable and bypass both 0 clears the stable flag
// R7: software never sets enable and bypass together
// R8: frequency field counts main clock cycles in sixteen slow periods
// R9: frequency-valid bit 16 is 1 only after enable or bypass and a finished measurement
// R10: first pll divider: 0 gives zero, 1 passes, 2-255 divide
// R11: each first pll write waits its count of slow cycles, then locks
// R12: first pll multiplier 0 is off, otherwise output is input times value+1
// R13: software writes bit 29 as 1 into the first pll register
// R14: second pll divider: 0 gives zero, 1 passes, 2-255 divide
// R15: each second pll write waits its count of slow cycles, then locks
// R16: second pll multiplier 0 is off, otherwise input times value+1
// R17: usb divider gives pll output divided by 1, 2 or 4; 11 reserved
// R18: software programs each pll range field to suit the output frequency
// R19: status register stable flag reads 1 when oscillator is stabilized
// R20: writing 1 to a peripheral enable bit starts that peripheral clock
// R21: a pll write clears its lock flag and restarts its counter
// R22: writes to read-only status and frequency registers are ignored
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module clock_generator (
   input  wire logic                                i_clk,
   input  wire logic                                i_rst_n,
   input  wire logic [clkgen_pkg::ADDR_W-1:0]       i_addr,
   input  wire logic [clkgen_pkg::DATA_W-1:0]       i_wdata,
   input  wire logic                                i_wr,
   input  wire logic                                i_rd,
   output logic      [clkgen_pkg::DATA_W-1:0]       o_rdata,
   input  wire logic                                i_slow_clk,
   input  wire logic                                i_main_clk,
   output logic                                     o_main_osc_enable,
   output logic                                     o_main_clk_from_pin,
   output logic                                     o_main_osc_stable,
   output logic      [clkgen_pkg::DATA_W-1:0]       o_periph_clock_en,
   output clkgen_pkg::pll_ctrl_t                    o_first_pll,
   output clkgen_pkg::pll_ctrl_t                    o_second_pll,
   output logic      [2:0]                          o_usb_divisor
);

   typedef struct packed {
      logic                                   slow_meta;
      logic                                   slow_sync;
      logic                                   slow_prev;
      logic                                   main_meta;
      logic                                   main_sync;
      logic                                   main_prev;
      logic [clkgen_pkg::DATA_W-1:0]          periph;
      logic                                   osc_en;
      logic                                   osc_byp;
      logic [clkgen_pkg::OSC_CNT_W-1:0]       osc_count;
      logic                                   osc_stable;
      logic [clkgen_pkg::DATA_W-1:0]          first_cfg;
      logic [clkgen_pkg::DATA_W-1:0]          second_cfg;
      logic                                   lock_first;
      logic                                   lock_second;
      clkgen_pkg::meas_state_t                meas;
      logic [4:0]                             meas_ticks;
      logic [clkgen_pkg::FREQ_W-1:0]          meas_count;
      logic [clkgen_pkg::FREQ_W-1:0]          freq;
      logic                                   freq_valid;
      logic [clkgen_pkg::DATA_W-1:0]          rdata;
      clkgen_pkg::pll_ctrl_t                  first_dec;
      clkgen_pkg::pll_ctrl_t                  second_dec;
      logic [2:0]                             usb_divisor;
   } gen_state_t;

   gen_state_t st;
   gen_state_t next_st;

   logic                           slow_tick;
   logic                           main_edge;
   logic                           wr_osc;
   logic                           wr_first;
   logic                           wr_second;
   logic                           osc_rise;
   logic                           osc_off;
   logic [clkgen_pkg::CNT_W-1:0]   osc_load_value;
   logic [clkgen_pkg::CNT_W-1:0]   first_load_value;
   logic [clkgen_pkg::CNT_W-1:0]   second_load_value;
   logic                           osc_done;
   logic                           first_done;
   logic                           second_done;
   logic                           new_en;
   logic                           new_byp;

   function automatic logic [2:0] usb_factor(input logic [1:0] code);
      logic [2:0] f;
      f = 3'h0;
      unique case (clkgen_pkg::usb_div_t'(code))
         clkgen_pkg::USB_DIV_1:    f = 3'h1;
         clkgen_pkg::USB_DIV_2:    f = 3'h2;
         clkgen_pkg::USB_DIV_4:    f = 3'h4;
         clkgen_pkg::USB_DIV_RSVD: f = 3'h0;
      endcase
      return f;
   endfunction

   // edges seen only on the second synchroniser stage
   assign slow_tick = st.slow_sync & ~st.slow_prev;
   assign main_edge = st.main_sync & ~st.main_prev;

   assign wr_osc    = i_wr && (i_addr == clkgen_pkg::OFF_OSC_CTRL);
   assign wr_first  = i_wr && (i_addr == clkgen_pkg::OFF_FIRST_PLL);
   assign wr_second = i_wr && (i_addr == clkgen_pkg::OFF_SECOND_PLL);

   assign new_en   = i_wdata[clkgen_pkg::OSC_EN_BIT];
   assign new_byp  = i_wdata[clkgen_pkg::OSC_BYP_BIT];
   assign osc_rise = wr_osc && new_en && !st.osc_en;                     // [R2]
   assign osc_off  = wr_osc && !new_en;                                  // [R2]

   // count times eight slow ticks, plus one unless zero so a partial first period never counts
   function automatic logic [clkgen_pkg::CNT_W-1:0] startup_ticks(
      input logic [clkgen_pkg::DATA_W-1:0] cfg);
      logic [clkgen_pkg::CNT_W-1:0] r;
      r = clkgen_pkg::CNT_W'(cfg[clkgen_pkg::OSC_CNT_LSB +: clkgen_pkg::OSC_CNT_W]) *
          clkgen_pkg::CNT_W'(clkgen_pkg::STARTUP_TICKS_PER_COUNT);        // [R4]
      return (r == '0) ? r : r + 1'b1;                                    // [R3]
   endfunction
   assign osc_load_value = startup_ticks(i_wdata);
   assign first_load_value  = clkgen_pkg::CNT_W'(i_wdata[clkgen_pkg::PLL_CNT_LSB +:
                                                          clkgen_pkg::PLL_CNT_W]);
   assign second_load_value = clkgen_pkg::CNT_W'(i_wdata[clkgen_pkg::PLL_CNT_LSB +:
                                                          clkgen_pkg::PLL_CNT_W]);

   slow_tick_counter u_osc_wait (
      .i_clk        (i_clk),
      .i_rst_n      (i_rst_n),
      .i_load       (osc_rise),
      .i_stop       (osc_off),
      .i_load_value (osc_load_value),
      .i_tick       (slow_tick),
      .o_done       (osc_done)
   );

   slow_tick_counter u_first_lock (
      .i_clk        (i_clk),
      .i_rst_n      (i_rst_n),
      .i_load       (wr_first),
      .i_stop       (1'b0),
      .i_load_value (first_load_value),
      .i_tick       (slow_tick),
      .o_done       (first_done)
   );

   slow_tick_counter u_second_lock (
      .i_clk        (i_clk),
      .i_rst_n      (i_rst_n),
      .i_load       (wr_second),
      .i_stop       (1'b0),
      .i_load_value (second_load_value),
      .i_tick       (slow_tick),
      .o_done       (second_done)
   );

   always_comb begin
      next_st = st;

      next_st.slow_meta = i_slow_clk;
      next_st.slow_sync = st.slow_meta;
      next_st.slow_prev = st.slow_sync;
      next_st.main_meta = i_main_clk;
      next_st.main_sync = st.main_meta;
      next_st.main_prev = st.main_sync;

      // peripheral clock enable and disable
      if (i_wr && i_addr == clkgen_pkg::OFF_PERIPH_ENABLE) begin
         next_st.periph = (st.periph | i_wdata) & clkgen_pkg::PERIPH_MASK;   // [R20] [R1]
      end
      if (i_wr && i_addr == clkgen_pkg::OFF_PERIPH_DISABLE) begin
         next_st.periph = st.periph & ~i_wdata & clkgen_pkg::PERIPH_MASK;    // [R1]
      end

      // oscillator control
      if (wr_osc) begin
         next_st.osc_en    = new_en;                                     // [R2]
         next_st.osc_byp   = new_byp;                                    // [R5]
         next_st.osc_count = i_wdata[clkgen_pkg::OSC_CNT_LSB +: clkgen_pkg::OSC_CNT_W];
      end
      if (next_st.osc_byp) begin
         next_st.osc_stable = 1'b1;                                      // [R5] [R19]
      end else if (!next_st.osc_en) begin
         next_st.osc_stable = 1'b0;                                      // [R6]
      end else if (osc_rise) begin
         next_st.osc_stable = 1'b0;                                      // [R3]
      end else begin
         next_st.osc_stable = osc_done;                                  // [R3] [R19]
      end

      // pll configuration and lock
      if (wr_first) begin
         next_st.first_cfg  = i_wdata;                                   // [R13]
         next_st.lock_first = 1'b0;                                      // [R21]
      end else begin
         next_st.lock_first = first_done &&
            (st.first_cfg[clkgen_pkg::PLL_MUL_LSB +: clkgen_pkg::PLL_MUL_W] != '0); // [R11] [R12]
      end
      if (wr_second) begin
         next_st.second_cfg  = i_wdata;
         next_st.lock_second = 1'b0;                                     // [R21]
      end else begin
         next_st.lock_second = second_done &&
            (st.second_cfg[clkgen_pkg::PLL_MUL_LSB +: clkgen_pkg::PLL_MUL_W] != '0); // [R15] [R16]
      end
      next_st.first_dec   = clkgen_pkg::decode_pll(next_st.first_cfg);   // [R10] [R12] [R18]
      next_st.second_dec  = clkgen_pkg::decode_pll(next_st.second_cfg);  // [R14] [R16] [R18]
      next_st.usb_divisor = usb_factor(
         next_st.second_cfg[clkgen_pkg::USB_DIV_LSB +: clkgen_pkg::USB_DIV_W]); // [R17]

      // frequency measurement over sixteen slow periods
      if (!next_st.osc_en && !next_st.osc_byp) begin
         next_st.meas       = clkgen_pkg::MEAS_IDLE;
         next_st.freq_valid = 1'b0;                                      // [R9]
      end else begin
         unique case (st.meas)
            clkgen_pkg::MEAS_IDLE: begin
               if (st.osc_stable) begin
                  next_st.meas = clkgen_pkg::MEAS_ARM;
               end
            end
            clkgen_pkg::MEAS_ARM: begin
               // align the window on a slow clock edge
               if (slow_tick) begin
                  next_st.meas       = clkgen_pkg::MEAS_RUN;
                  next_st.meas_ticks = 5'h00;
                  next_st.meas_count = '0;
               end
            end
            clkgen_pkg::MEAS_RUN: begin
               if (main_edge && st.meas_count != '1) begin
                  next_st.meas_count = st.meas_count + 1'b1;             // [R8]
               end
               if (slow_tick) begin
                  next_st.meas_ticks = st.meas_ticks + 5'h01;
                  if (st.meas_ticks + 5'h01 == clkgen_pkg::MEAS_WINDOW) begin
                     next_st.meas       = clkgen_pkg::MEAS_DONE;
                     next_st.freq       = next_st.meas_count;            // [R8]
                     next_st.freq_valid = 1'b1;                          // [R9]
                  end
               end
            end
            clkgen_pkg::MEAS_DONE: begin
               next_st.meas = clkgen_pkg::MEAS_DONE;
            end
         endcase
         if (osc_rise) begin
            next_st.meas       = clkgen_pkg::MEAS_IDLE;
            next_st.freq_valid = 1'b0;                                   // [R9]
         end
      end

      // read data, one cycle after the strobe; writes to read-only ones fall through
      next_st.rdata = '0;                                                // [R22]
      if (i_rd) begin
         unique case (i_addr)
            clkgen_pkg::OFF_PERIPH_STATE: begin
               next_st.rdata = st.periph & clkgen_pkg::PERIPH_MASK;      // [R1]
            end
            clkgen_pkg::OFF_OSC_CTRL: begin
               next_st.rdata[clkgen_pkg::OSC_EN_BIT]  = st.osc_en;
               next_st.rdata[clkgen_pkg::OSC_BYP_BIT] = st.osc_byp;
               next_st.rdata[clkgen_pkg::OSC_CNT_LSB +: clkgen_pkg::OSC_CNT_W] = st.osc_count;
            end
            clkgen_pkg::OFF_FREQ: begin
               next_st.rdata[clkgen_pkg::FREQ_LSB +: clkgen_pkg::FREQ_W] = st.freq;
               next_st.rdata[clkgen_pkg::FREQ_VALID_BIT] = st.freq_valid;  // [R9]
            end
            clkgen_pkg::OFF_FIRST_PLL: begin
               next_st.rdata = st.first_cfg;
            end
            clkgen_pkg::OFF_SECOND_PLL: begin
               next_st.rdata = st.second_cfg;
            end
            clkgen_pkg::OFF_STATUS: begin
               next_st.rdata = clkgen_pkg::STATUS_FIXED;
               next_st.rdata[clkgen_pkg::STAT_OSC_BIT]   = st.osc_stable;    // [R19]
               next_st.rdata[clkgen_pkg::STAT_FIRST_PLL_LOCK_FLAG_BIT] = st.lock_first;    // [R11]
               next_st.rdata[clkgen_pkg::STAT_SECOND_PLL_LOCK_FLAG_BIT] = st.lock_second;   // [R15]
            end
            default: begin
               next_st.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st            <= '0;
         st.periph     <= clkgen_pkg::PERIPH_RST;
         st.osc_count  <= clkgen_pkg::OSC_CNT_RST;
         st.first_cfg  <= clkgen_pkg::PLL_RST;
         st.second_cfg <= clkgen_pkg::PLL_RST;
         st.meas       <= clkgen_pkg::MEAS_IDLE;
         st.first_dec  <= clkgen_pkg::decode_pll(clkgen_pkg::PLL_RST);
         st.second_dec <= clkgen_pkg::decode_pll(clkgen_pkg::PLL_RST);
         st.usb_divisor <= 3'h1;
      end else begin
         st <= next_st;
      end
   end

   assign o_rdata             = st.rdata;
   assign o_main_osc_enable   = st.osc_en;                               // [R2]
   assign o_main_clk_from_pin = st.osc_byp;                              // [R5]
   assign o_main_osc_stable   = st.osc_stable;
   assign o_periph_clock_en   = st.periph;                               // [R20]
   assign o_first_pll         = st.first_dec;
   assign o_second_pll        = st.second_dec;
   assign o_usb_divisor       = st.usb_divisor;

endmodule
`default_nettype wire

// ==== dv/clock_generator_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module clock_generator_sva (
   input wire logic                          i_clk,
   input wire logic                          i_rst_n,
   input wire logic [clkgen_pkg::ADDR_W-1:0] i_addr,
   input wire logic [clkgen_pkg::DATA_W-1:0] i_wdata,
   input wire logic                          i_wr,
   input wire logic                          i_rd,
   input wire logic [clkgen_pkg::DATA_W-1:0] o_rdata,
   input wire logic                          i_slow_clk,
   input wire logic                          i_main_clk,
   input wire logic                          o_main_osc_enable,
   input wire logic                          o_main_clk_from_pin,
   input wire logic                          o_main_osc_stable,
   input wire logic [clkgen_pkg::DATA_W-1:0] o_periph_clock_en,
   input wire clkgen_pkg::pll_ctrl_t         o_first_pll,
   input wire clkgen_pkg::pll_ctrl_t         o_second_pll,
   input wire logic [2:0]                    o_usb_divisor
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic wr_osc, wr_a, wr_b;
   assign wr_osc = i_wr && (i_addr == clkgen_pkg::OFF_OSC_CTRL);
   assign wr_a   = i_wr && (i_addr == clkgen_pkg::OFF_FIRST_PLL);
   assign wr_b   = i_wr && (i_addr == clkgen_pkg::OFF_SECOND_PLL);
   periph_low_a: assert property (o_periph_clock_en[1:0] == 2'h0)
      else $error("low peripheral bits set");
   osc_enable_a: assert property (wr_osc |=> o_main_osc_enable == $past(i_wdata[0]))
      else $error("enable bit not taken");
   startup_wait_a: assert property (wr_osc && i_wdata[1:0] == 2'b01
      && i_wdata[15:8] != 8'h00 && !o_main_osc_enable && !o_main_osc_stable
      |=> !o_main_osc_stable [*8]) else $error("stable flag too early");
   bypass_stable_a: assert property (wr_osc && i_wdata[1] |=>
      o_main_osc_stable && o_main_clk_from_pin) else $error("bypass did not set stable");
   osc_clear_a: assert property (wr_osc && i_wdata[1:0] == 2'b00 |=> !o_main_osc_stable)
      else $error("stable flag not cleared");
   first_pll_a: assert property (wr_a |=> o_first_pll.on == |$past(i_wdata[26:16])
      && o_first_pll.mult_factor == $past(i_wdata[26:16]) + 12'h001
      && o_first_pll.ref_zero == ($past(i_wdata[7:0]) == 8'h00))
      else $error("first pll decode wrong");
   second_pll_a: assert property (wr_b |=> o_second_pll.on == |$past(i_wdata[26:16])
      && o_second_pll.mult_factor == $past(i_wdata[26:16]) + 12'h001
      && o_second_pll.ref_bypass == ($past(i_wdata[7:0]) == 8'h01))
      else $error("second pll decode wrong");
   usb_div_a: assert property (wr_b |=> o_usb_divisor ==
      (($past(i_wdata[29:28]) == 2'b11) ? 3'h0 : (3'h1 << $past(i_wdata[29:28]))))
      else $error("usb divisor wrong");
   periph_on_a: assert property (i_wr && i_addr == clkgen_pkg::OFF_PERIPH_ENABLE |=>
      o_periph_clock_en == $past((o_periph_clock_en | i_wdata) & clkgen_pkg::PERIPH_MASK))
      else $error("peripheral enable wrong");
   ro_ignore_a: assert property (i_wr && (i_addr == clkgen_pkg::OFF_PERIPH_STATE
      || i_addr == clkgen_pkg::OFF_FREQ) |=> $stable({o_periph_clock_en, o_main_osc_enable}))
      else $error("read-only write had effect");
endmodule
bind clock_generator clock_generator_sva chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_slow_clk(i_slow_clk),
   .i_main_clk(i_main_clk), .o_main_osc_enable(o_main_osc_enable),
   .o_main_clk_from_pin(o_main_clk_from_pin), .o_main_osc_stable(o_main_osc_stable),
   .o_periph_clock_en(o_periph_clock_en), .o_first_pll(o_first_pll),
   .o_second_pll(o_second_pll), .o_usb_divisor(o_usb_divisor));
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin failures++; \
   $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
   typedef struct packed {
      logic [27:0] wa;
      logic [31:0] wd;
      logic [27:0] ra;
      logic [31:0] ex;
   } row_t;
   logic                  i_clk, i_rst_n, i_wr, i_rd, i_slow_clk, i_main_clk;
   logic [27:0]           i_addr;
   logic [31:0]           i_wdata, o_rdata, o_periph_clock_en, d;
   logic                  o_main_osc_enable, o_main_clk_from_pin, o_main_osc_stable;
   clkgen_pkg::pll_ctrl_t o_first_pll, o_second_pll;
   logic [2:0]            o_usb_divisor;
   int                    failures = 0, total_checks = 0, cyc = 0, n;
   row_t                  rows [8];
   clock_generator dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_slow_clk(i_slow_clk),
      .i_main_clk(i_main_clk), .o_main_osc_enable(o_main_osc_enable),
      .o_main_clk_from_pin(o_main_clk_from_pin), .o_main_osc_stable(o_main_osc_stable),
      .o_periph_clock_en(o_periph_clock_en), .o_first_pll(o_first_pll),
      .o_second_pll(o_second_pll), .o_usb_divisor(o_usb_divisor));
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   // slow clock every 8 cycles, main clock every 4
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      i_slow_clk <= cyc[2];
      i_main_clk <= cyc[1];
      if (cyc == 20000) begin
         failures++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(input logic [27:0] a, input logic [31:0] v);
      @(posedge i_clk);
      i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [27:0] a, output logic [31:0] v);
      @(posedge i_clk);
      i_rd <= 1'b1; i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask
   initial begin
      i_rst_n = 1'b0; i_wr = 1'b0; i_rd = 1'b0; i_addr = '0; i_wdata = '0;
      rows[0] = {28'hFFFFC10, 32'hFFFFFFFF, clkgen_pkg::OFF_PERIPH_STATE, 32'hFFFFFFFC};
      rows[1] = {28'hFFFFC18, 32'h00000000, clkgen_pkg::OFF_PERIPH_STATE, 32'hFFFFFFFC};
      rows[2] = {28'hFFFFC14, 32'h000000F3, clkgen_pkg::OFF_PERIPH_STATE, 32'hFFFFFF0C};
      rows[3] = {clkgen_pkg::OFF_FIRST_PLL, 32'h20003F05, clkgen_pkg::OFF_FIRST_PLL, 32'h20003F05};
      rows[4] = {28'hFFFFC2C, 32'h3FFFFFFF, clkgen_pkg::OFF_SECOND_PLL, 32'h3FFFFFFF};
      rows[5] = {clkgen_pkg::OFF_FREQ, 32'hFFFFFFFF, clkgen_pkg::OFF_FREQ, 32'h00000000};
      rows[6] = {28'hFFFFC30, 32'h12345678, 28'hFFFFC30, 32'h00000000};
      rows[7] = {clkgen_pkg::OFF_STATUS, 32'hFFFFFFFF, clkgen_pkg::OFF_STATUS, 32'h00000008};
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].wa, rows[i].wd);
         rd(rows[i].ra, d);
         `CHECK("register row", rows[i].ex, d)
      end
      $display("register table done");
      wr(clkgen_pkg::OFF_OSC_CTRL, 32'h00000201);
      `CHECK("osc enable", 1'b1, o_main_osc_enable)
      repeat (100) @(posedge i_clk);
      #1 `CHECK("stable early", 1'b0, o_main_osc_stable)
      n = 100;
      while (o_main_osc_stable !== 1'b1 && n < 160) begin
         @(posedge i_clk) #1;
         n++;
      end
      `CHECK("startup span", 1'b1, n >= 128 && n <= 140)
      rd(clkgen_pkg::OFF_STATUS, d);
      `CHECK("status stable", 1'b1, d[0])
      repeat (200) @(posedge i_clk);
      rd(clkgen_pkg::OFF_FREQ, d);
      `CHECK("freq valid", 1'b1, d[16])
      `CHECK("freq count", 1'b1, d[15:0] >= 16'h001E && d[15:0] <= 16'h0022)
      wr(clkgen_pkg::OFF_OSC_CTRL, 32'h00000000);
      `CHECK("stable cleared", 1'b0, o_main_osc_stable)
      rd(clkgen_pkg::OFF_FREQ, d);
      `CHECK("freq valid off", 1'b0, d[16])
      wr(clkgen_pkg::OFF_OSC_CTRL, 32'h00000002);
      `CHECK("bypass stable", 2'b11, {o_main_osc_stable, o_main_clk_from_pin})
      wr(clkgen_pkg::OFF_OSC_CTRL, 32'h00000000);
      $display("oscillator done");
      wr(clkgen_pkg::OFF_FIRST_PLL, 32'h2001C305);
      `CHECK("first decode", 25'h101400B, o_first_pll)
      rd(clkgen_pkg::OFF_STATUS, d);
      `CHECK("lock a clear", 1'b0, d[1])
      repeat (40) @(posedge i_clk);
      rd(clkgen_pkg::OFF_STATUS, d);
      `CHECK("lock a set", 1'b1, d[1])
      wr(clkgen_pkg::OFF_FIRST_PLL, 32'h20010301);
      rd(clkgen_pkg::OFF_STATUS, d);
      `CHECK("lock a rewrite", 1'b0, d[1])
      for (int k = 0; k < 4; k++) begin
         wr(clkgen_pkg::OFF_SECOND_PLL, 32'h00010200 | (32'(k) << 28));
         `CHECK("usb divisor", (k == 3) ? 3'h0 : 3'h1 << k, o_usb_divisor)
         `CHECK("second zero", 1'b1, o_second_pll.ref_zero)
      end
      repeat (40) @(posedge i_clk);
      rd(clkgen_pkg::OFF_STATUS, d);
      `CHECK("lock b set", 1'b1, d[2])
      wr(clkgen_pkg::OFF_SECOND_PLL, 32'h0000C207);
      `CHECK("second off", 25'h001C007, o_second_pll)
      repeat (40) @(posedge i_clk);
      rd(clkgen_pkg::OFF_STATUS, d);
      `CHECK("lock b off", 1'b0, d[2])
      $display("pll done");
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      #1;
      `CHECK("reset usb", 3'h1, o_usb_divisor)
      `CHECK("reset periph", 32'h00000000, o_periph_clock_en)
      rd(clkgen_pkg::OFF_STATUS, d);
      `CHECK("reset status", 32'h00000008, d)
      $display("reset done");
      stop_test();
   end
endmodule
`default_nettype wire
